// [src/i2c_status_irq_regs.svh]
// Notes on behaviour
// - general call address received while general_call_respond set sets general_call_seen; START clears it.
// - received not-acknowledge sets nack_flag; START clears it.
// - detected STOP sets stop_flag; START clears it.
// - detected START sets start_flag; STOP clears it.
// - receive buffer keeps last character; reading it clears rx_flag.
// - transmit buffer holds next byte; writing it clears tx_flag.
// - general call answered only while general_call_respond (bit 15) set, or as own address while own address is zero.
// - own address right-justified; 7-bit uses bits 6-0, 10-bit bits 9-0.
// - target address used only as master; same 7/10-bit justification.
// - tx_irq_en (bit 3) and rx_irq_en (bit 2) gate tx and rx requests.
// - tx_flag, bit 3, resets to one; set when transmit buffer empties.
// - rx_flag, bit 2, resets to zero; set on complete received character.
`ifndef I2C_STATUS_IRQ_REGS_SVH
`define I2C_STATUS_IRQ_REGS_SVH

// register byte offsets
`define OFS_STATUS   8'h00
`define OFS_RXBUF    8'h04
`define OFS_TXBUF    8'h08
`define OFS_OWN      8'h0C
`define OFS_TARGET   8'h10
`define OFS_EVT_EN   8'h14
`define OFS_IRQ_EN   8'h18
`define OFS_IRQ_FLAG 8'h1C
`define OFS_MODE     8'h20

// field positions
`define BIT_SCL_LOW  6
`define BIT_GC       5
`define BIT_BUSY     4
`define BIT_NACK     3
`define BIT_STOP     2
`define BIT_START    1
`define BIT_ARB      0
`define BIT_TX       3
`define BIT_RX       2
`define BIT_GC_EN    15
`define BIT_OWN10    0
`define BIT_TGT10    1

// reset values and codes
`define RST_IRQ_FLAG 8'h08
`define RST_ZERO     8'h00
`define GC_ADDR      10'h000
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// [src/i2c_status_irq_pkg.sv]
package i2c_status_irq_pkg;

	// bus conditions seen on the two wires
	typedef struct packed {
		logic start;
		logic stop;
		logic scl_low;
	} cond_t;

	// received character from the shift register
	typedef struct packed {
		logic       strobe;
		logic [7:0] data;
	} rx_in_t;

	// received address from the shift register
	typedef struct packed {
		logic       strobe;
		logic [9:0] word;
	} addr_in_t;

endpackage

// [src/i2c_bus_monitor.sv]
`timescale 1ns/1ns
module i2c_bus_monitor (
	input  wire logic                         core_clk,
	input  wire logic                         rst,
	input  wire logic                         scl_in,
	input  wire logic                         sda_in,
	output i2c_status_irq_pkg::cond_t         cond
);
	import i2c_status_irq_pkg::*;

	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic       scl_f;
	logic       sda_f;

	// three-stage synchronisers on both pins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else begin
			scl_sync <= {scl_sync[1:0], scl_in};
			sda_sync <= {sda_sync[1:0], sda_in};
		end
	end

	// a level counts once stages two and three agree
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scl_f <= 1'b1;
			sda_f <= 1'b1;
		end else begin
			if (scl_sync[1] == scl_sync[2])
				scl_f <= scl_sync[2];
			if (sda_sync[1] == sda_sync[2])
				sda_f <= sda_sync[2];
		end
	end

	// start: data falls while clock high; stop: data rises while clock high
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cond <= '0;
		end else begin
			cond.start   <= scl_f && scl_sync[2] && sda_f &&
			                (sda_sync[1] == sda_sync[2]) && !sda_sync[2];
			cond.stop    <= scl_f && scl_sync[2] && !sda_f &&
			                (sda_sync[1] == sda_sync[2]) && sda_sync[2];
			cond.scl_low <= !scl_f;
		end
	end

endmodule

// [src/i2c_status_irq_regs.sv]
`timescale 1ns/1ns
`include "i2c_status_irq_regs.svh"
module i2c_status_irq_regs #(
	parameter int ADDR_W = 8
) (
	input  wire logic                         core_clk,
	input  wire logic                         rst,
	// axi4-lite slave
	input  wire logic                         awvalid,
	output logic                              awready,
	input  wire logic [ADDR_W-1:0]            awaddr,
	input  wire logic                         wvalid,
	output logic                              wready,
	input  wire logic [31:0]                  wdata,
	input  wire logic [3:0]                   wstrb,
	output logic                              bvalid,
	input  wire logic                         bready,
	output logic [1:0]                        bresp,
	input  wire logic                         arvalid,
	output logic                              arready,
	input  wire logic [ADDR_W-1:0]            araddr,
	output logic                              rvalid,
	input  wire logic                         rready,
	output logic [31:0]                       rdata,
	output logic [1:0]                        rresp,
	// two-wire bus pins, observed only
	input  wire logic                         scl_in,
	input  wire logic                         sda_in,
	// shift datapath and bus engine
	input  wire logic                         nack_rcvd,
	input  wire logic                         arb_lost,
	input  wire logic                         master_mode,
	input  wire i2c_status_irq_pkg::rx_in_t   rx_in,
	input  wire i2c_status_irq_pkg::addr_in_t addr_in,
	input  wire logic                         tx_char_taken,
	output logic                              tx_char_valid,
	output logic [7:0]                        tx_char,
	output logic                              addr_ack,
	output logic                              addr_gc,
	output logic [9:0]                        target_addr_out,
	output logic                              irq
);
	import i2c_status_irq_pkg::*;

	cond_t             cond;
	logic              aw_full;
	logic              w_full;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              wr_go;
	logic              rd_go;
	logic              lo;
	logic              hi;
	logic [31:0]       rd_word;
	// status flags
	logic              scl_held_low;
	logic              general_call_seen;
	logic              bus_busy_flag;
	logic              nack_flag;
	logic              stop_flag;
	logic              start_flag;
	logic              arb_lost_flag;
	// buffers and flags
	logic [7:0]        rx_char;
	logic              rx_flag;
	logic              tx_flag;
	// configuration
	logic              general_call_respond;
	logic [9:0]        own_addr_field;
	logic [9:0]        target_addr_field;
	logic              nack_irq_en;
	logic              stop_irq_en;
	logic              start_irq_en;
	logic              arb_lost_irq_en;
	logic              tx_irq_en;
	logic              rx_irq_en;
	logic              own_10bit;
	logic              tgt_10bit;
	logic              gc_hit;
	logic              own_hit;
	logic              pend;

	// right-justified address in 7- or 10-bit form
	function automatic logic [9:0] eff_addr(input logic [9:0] a,
	                                        input logic       ten);
		eff_addr = ten ? a : {3'h0, a[6:0]};
	endfunction

	// true for every implemented register offset
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a == `OFS_STATUS) || (a == `OFS_RXBUF) ||
		         (a == `OFS_TXBUF)  || (a == `OFS_OWN)   ||
		         (a == `OFS_TARGET) || (a == `OFS_EVT_EN) ||
		         (a == `OFS_IRQ_EN) || (a == `OFS_IRQ_FLAG) ||
		         (a == `OFS_MODE);
	endfunction

	i2c_bus_monitor u_mon (
		.core_clk (core_clk),
		.rst      (rst),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.cond     (cond)
	);

	// write commits once address and data are both held
	assign wr_go = aw_full && w_full && !bvalid;
	assign rd_go = arvalid && arready;
	assign lo    = w_strb_q[0];
	assign hi    = w_strb_q[1];

	// write address channel
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			awready   <= 1'b1;
			aw_full   <= 1'b0;
			aw_addr_q <= '0;
		end else if (awvalid && awready) begin
			awready   <= 1'b0;
			aw_full   <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (bvalid && bready) begin
			awready   <= 1'b1;
			aw_full   <= 1'b0;
		end
	end

	// write data channel
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wready   <= 1'b1;
			w_full   <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (wvalid && wready) begin
			wready   <= 1'b0;
			w_full   <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (bvalid && bready) begin
			wready   <= 1'b1;
			w_full   <= 1'b0;
		end
	end

	// write response, error on unmapped offsets
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp  <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// read data selection
	always_comb begin
		rd_word = '0;
		unique case (araddr)
			`OFS_STATUS: rd_word[7:0] = {1'b0, scl_held_low,
			                         general_call_seen, bus_busy_flag,
			                         nack_flag, stop_flag, start_flag,
			                         arb_lost_flag};
			`OFS_RXBUF:  rd_word[7:0] = rx_char;
			`OFS_TXBUF:  rd_word[7:0] = tx_char;
			`OFS_OWN:    rd_word[15:0] = {general_call_respond, 5'h00,
			                              own_addr_field};
			`OFS_TARGET: rd_word[9:0] = target_addr_field;
			`OFS_EVT_EN: rd_word[3:0] = {nack_irq_en, stop_irq_en,
			                             start_irq_en, arb_lost_irq_en};
			`OFS_IRQ_EN:   rd_word[3:2] = {tx_irq_en, rx_irq_en};
			`OFS_IRQ_FLAG: rd_word[3:2] = {tx_flag, rx_flag};
			`OFS_MODE:   rd_word[1:0] = {tgt_10bit, own_10bit};
			default:     rd_word = '0;
		endcase
	end

	// read address and data channels
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= `RESP_OKAY;
		end else if (rd_go) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_word;
			rresp   <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	// configuration registers written by software
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			general_call_respond <= 1'b0;
			own_addr_field       <= '0;
			target_addr_field    <= '0;
			{nack_irq_en, stop_irq_en}      <= 2'h0;
			{start_irq_en, arb_lost_irq_en} <= 2'h0;
			{tx_irq_en, rx_irq_en}          <= 2'h0;
			{tgt_10bit, own_10bit}          <= 2'h0;
		end else if (wr_go) begin
			if (aw_addr_q == `OFS_OWN) begin
				if (lo)
					own_addr_field[7:0] <= w_data_q[7:0];
				if (hi) begin
					own_addr_field[9:8]  <= w_data_q[9:8];
					general_call_respond <= w_data_q[`BIT_GC_EN];
				end
			end
			if (aw_addr_q == `OFS_TARGET) begin
				if (lo)
					target_addr_field[7:0] <= w_data_q[7:0];
				if (hi)
					target_addr_field[9:8] <= w_data_q[9:8];
			end
			if (aw_addr_q == `OFS_EVT_EN && lo) begin
				nack_irq_en     <= w_data_q[`BIT_NACK];
				stop_irq_en     <= w_data_q[`BIT_STOP];
				start_irq_en    <= w_data_q[`BIT_START];
				arb_lost_irq_en <= w_data_q[`BIT_ARB];
			end
			if (aw_addr_q == `OFS_IRQ_EN && lo) begin
				tx_irq_en <= w_data_q[`BIT_TX];
				rx_irq_en <= w_data_q[`BIT_RX];
			end
			if (aw_addr_q == `OFS_MODE && lo) begin
				own_10bit <= w_data_q[`BIT_OWN10];
				tgt_10bit <= w_data_q[`BIT_TGT10];
			end
		end
	end

	// general call needs the respond bit; own address per mode
	assign gc_hit  = addr_in.strobe && addr_in.word == `GC_ADDR &&
	                 general_call_respond;
	assign own_hit = addr_in.strobe &&
	                 eff_addr(addr_in.word, own_10bit) ==
	                 eff_addr(own_addr_field, own_10bit);

	// address replies to the bus engine, target only in master mode
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addr_ack        <= 1'b0;
			addr_gc         <= 1'b0;
			target_addr_out <= '0;
		end else begin
			addr_ack        <= gc_hit || own_hit;
			addr_gc         <= gc_hit;
			target_addr_out <= master_mode ?
			                   eff_addr(target_addr_field, tgt_10bit) :
			                   10'h000;
		end
	end

	// live bus levels
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bus_busy_flag <= 1'b0;
			scl_held_low  <= 1'b0;
		end else begin
			scl_held_low <= cond.scl_low;
			if (cond.stop)
				bus_busy_flag <= 1'b0;
			if (cond.start)
				bus_busy_flag <= 1'b1;
		end
	end

	// event flags: write zero clears, auto clears, then sets win
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			general_call_seen <= 1'b0;
			nack_flag         <= 1'b0;
			stop_flag         <= 1'b0;
			start_flag        <= 1'b0;
			arb_lost_flag     <= 1'b0;
		end else begin
			if (wr_go && aw_addr_q == `OFS_STATUS && lo) begin
				general_call_seen <= general_call_seen &&
				                     w_data_q[`BIT_GC];
				nack_flag     <= nack_flag && w_data_q[`BIT_NACK];
				stop_flag     <= stop_flag && w_data_q[`BIT_STOP];
				start_flag    <= start_flag && w_data_q[`BIT_START];
				arb_lost_flag <= arb_lost_flag &&
				                 w_data_q[`BIT_ARB];
			end
			if (cond.start) begin
				general_call_seen <= 1'b0;
				nack_flag         <= 1'b0;
				stop_flag         <= 1'b0;
			end
			if (cond.stop)
				start_flag <= 1'b0;
			if (gc_hit)
				general_call_seen <= 1'b1;
			if (nack_rcvd)
				nack_flag <= 1'b1;
			if (cond.stop)
				stop_flag <= 1'b1;
			if (cond.start)
				start_flag <= 1'b1;
			if (arb_lost && master_mode)
				arb_lost_flag <= 1'b1;
		end
	end

	// receive buffer and its flag; a new character beats the clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_char <= `RST_ZERO;
			rx_flag <= 1'(`RST_IRQ_FLAG >> `BIT_RX);
		end else begin
			if (rd_go && araddr == `OFS_RXBUF)
				rx_flag <= 1'b0;
			if (wr_go && aw_addr_q == `OFS_IRQ_FLAG && lo &&
			    !w_data_q[`BIT_RX])
				rx_flag <= 1'b0;
			if (rx_in.strobe) begin
				rx_char <= rx_in.data;
				rx_flag <= 1'b1;
			end
		end
	end

	// transmit buffer; a software write refills it after a take
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_char       <= `RST_ZERO;
			tx_char_valid <= 1'b0;
			tx_flag       <= 1'(`RST_IRQ_FLAG >> `BIT_TX);
		end else begin
			if (wr_go && aw_addr_q == `OFS_IRQ_FLAG && lo &&
			    !w_data_q[`BIT_TX])
				tx_flag <= 1'b0;
			if (tx_char_taken) begin
				tx_char_valid <= 1'b0;
				tx_flag       <= 1'b1;
			end
			if (wr_go && aw_addr_q == `OFS_TXBUF && lo) begin
				tx_char       <= w_data_q[7:0];
				tx_char_valid <= 1'b1;
				tx_flag       <= 1'b0;
			end
		end
	end

	// interrupt request: any flag together with its enable
	assign pend = (nack_flag && nack_irq_en) ||
	              (stop_flag && stop_irq_en) ||
	              (start_flag && start_irq_en) ||
	              (arb_lost_flag && arb_lost_irq_en) ||
	              (tx_flag && tx_irq_en) ||
	              (rx_flag && rx_irq_en);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= pend;
	end

	// checks next to the logic
	a_gc_sets_flag: assert property (
		@(posedge core_clk) disable iff (rst)
		gc_hit |=> general_call_seen)
		else $error("general call did not set its flag");

	a_nack_start: assert property (
		@(posedge core_clk) disable iff (rst)
		(nack_rcvd |=> nack_flag) and
		(cond.start && !nack_rcvd |=> !nack_flag))
		else $error("nack flag set or clear wrong");

	a_stop_sets: assert property (
		@(posedge core_clk) disable iff (rst)
		cond.stop |=> stop_flag && !start_flag && !bus_busy_flag)
		else $error("stop did not set stop flag or clear start");

	a_start_sets: assert property (
		@(posedge core_clk) disable iff (rst)
		cond.start && !gc_hit |=> start_flag && !stop_flag &&
		!general_call_seen && bus_busy_flag)
		else $error("start did not update flags");

	a_rx_read_clr: assert property (
		@(posedge core_clk) disable iff (rst)
		rd_go && araddr == `OFS_RXBUF && !rx_in.strobe |=> !rx_flag)
		else $error("receive buffer read left rx flag set");

	a_tx_write_clr: assert property (
		@(posedge core_clk) disable iff (rst)
		wr_go && aw_addr_q == `OFS_TXBUF && lo |=>
		!tx_flag && tx_char_valid && tx_char == $past(w_data_q[7:0]))
		else $error("transmit buffer write handled wrong");

	a_gc_ignored: assert property (
		@(posedge core_clk) disable iff (rst)
		addr_in.strobe && addr_in.word == `GC_ADDR &&
		!general_call_respond && own_addr_field != 10'h000 |=>
		!addr_ack && !addr_gc)
		else $error("general call answered while disabled");

	a_target_master: assert property (
		@(posedge core_clk) disable iff (rst)
		!master_mode |=> target_addr_out == 10'h000)
		else $error("target address driven outside master mode");

	a_tx_empty_set: assert property (
		@(posedge core_clk) disable iff (rst)
		tx_char_taken && !(wr_go && aw_addr_q == `OFS_TXBUF && lo)
		|=> tx_flag && !tx_char_valid)
		else $error("tx flag not set on empty buffer");

	a_rx_char_set: assert property (
		@(posedge core_clk) disable iff (rst)
		rx_in.strobe |=> rx_flag && rx_char == $past(rx_in.data))
		else $error("received character not captured");

	a_irq_follows: assert property (
		@(posedge core_clk) disable iff (rst)
		##1 irq == $past(pend))
		else $error("interrupt does not follow flags and enables");

	a_scl_low: assert property (
		@(posedge core_clk) disable iff (rst)
		cond.scl_low |=> scl_held_low)
		else $error("clock low not reported");

	a_arb_lost: assert property (
		@(posedge core_clk) disable iff (rst)
		arb_lost && master_mode |=> arb_lost_flag)
		else $error("arbitration loss not flagged");

endmodule

// [sim/i2c_bus_partner.sv]
`timescale 1ns/1ns
module i2c_bus_partner (
	input  wire logic core_clk,
	output logic      scl,
	output logic      sda
);
	// released bus: both lines sit at the pull-up level
	initial begin
		scl = 1'h1;
		sda = 1'h1;
	end
	// one bus phase of h cycles, so slow and prompt peers both occur
	task automatic step(input logic c, input logic s, input int h);
		scl <= c;
		sda <= s;
		repeat (h) @(posedge core_clk);
	endtask
	// start: data falls while clock high, then clock is held low
	task automatic start(input int h);
		step(1'h1, 1'h0, h);
		step(1'h0, 1'h0, h);
	endtask
	// stop: data rises while clock high and the bus is released
	task automatic stop(input int h);
		step(1'h0, 1'h0, h);
		step(1'h1, 1'h0, h);
		step(1'h1, 1'h1, h);
	endtask
endmodule

// [sim/i2c_status_irq_regs_test.sv]
`timescale 1ns/1ns
`include "i2c_status_irq_regs.svh"
module i2c_status_irq_regs_test;
	import i2c_status_irq_pkg::*;
	logic        core_clk, rst, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic        scl, sda, nack_rcvd, arb_lost, master_mode;
	logic        tx_char_taken, tx_char_valid, addr_ack, addr_gc, irq;
	logic [7:0]  awaddr, araddr, tx_char, b;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [9:0]  target_addr_out;
	rx_in_t      rx_in;
	addr_in_t    addr_in;
	int          err_total, comparisons;

	i2c_status_irq_regs DUT (
		.core_clk, .rst, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .rvalid, .rready, .rdata, .rresp, .scl_in(scl),
		.sda_in(sda), .nack_rcvd, .arb_lost, .master_mode, .rx_in,
		.addr_in, .tx_char_taken, .tx_char_valid, .tx_char, .addr_ack,
		.addr_gc, .target_addr_out, .irq
	);
	i2c_bus_partner P (.core_clk, .scl, .sda);

	// free-running core clock
	initial begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] e,
	                     input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	// one edge of a bounded wait; running out ends the run
	task automatic tick(inout int n);
		@(posedge core_clk);
		n++;
		if (n > 64) begin
			err_total++;
			close_out();
		end
	endtask
	// bus write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
	                  input logic [1:0] er);
		int   n;
		logic aw;
		logic w;
		n = 0;
		aw = 1'h0;
		w = 1'h0;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(aw && w)) begin
			tick(n);
			if (awvalid && awready) begin
				aw = 1'h1;
				awvalid <= 1'h0;
			end
			if (wvalid && wready) begin
				w = 1'h1;
				wvalid <= 1'h0;
			end
		end
		bready <= 1'h1;
		do tick(n); while (!bvalid);
		bready <= 1'h0;
		check("bresp", {30'h0, er}, {30'h0, bresp});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
	                  input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'h1;
		do tick(n); while (!arready);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do tick(n); while (!rvalid);
		rready <= 1'h0;
		v = rdata;
		check("rresp", {30'h0, er}, {30'h0, rresp});
	endtask
	task automatic rchk(input string n, input logic [7:0] a,
	                    input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v, `RESP_OKAY);
		check(n, e, v & m);
	endtask
	// address strobe from the shift datapath; answer one cycle later
	task automatic addr(input logic [9:0] w, input logic k, input logic g);
		addr_in <= '{strobe: 1'h1, word: w};
		cyc(1);
		addr_in <= '{strobe: 1'h0, word: w};
		cyc(1);
		check("addr_ack", {31'h0, k}, {31'h0, addr_ack});
		check("addr_gc", {31'h0, g}, {31'h0, addr_gc});
	endtask
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask
	// expected right-justified address: 7-bit form keeps bits 6-0
	function automatic logic [31:0] exp_addr(input logic [9:0] a,
	                                         input logic       ten);
		exp_addr = ten ? {22'h0, a} : {25'h0, a[6:0]};
	endfunction

	// watchdog against a hung run
	initial begin
		cyc(90000);
		err_total++;
		close_out();
	end

	// main sequence
	initial begin
		err_total = 0;
		comparisons = 0;
		rst = 1'h1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{nack_rcvd, arb_lost, master_mode, tx_char_taken} = 4'h0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		rx_in = '0;
		addr_in = '0;
		void'($urandom(32'h6449_3469));
		cyc(20);
		rst <= 1'h0;
		cyc(1);
		rchk("flags", `OFS_IRQ_FLAG, 32'h0000_000C, 32'h0000_0008);
		rchk("status", `OFS_STATUS, 32'h0000_00FF, 32'h0000_0000);
		rd(8'h24, d, `RESP_SLVERR);
		check("unmapped", 32'h0000_0000, d);
		wr(`OFS_IRQ_EN, 32'h0000_0008, `RESP_OKAY);
		cyc(3);
		check("irq", 32'h0000_0001, {31'h0, irq});
		wr(`OFS_IRQ_EN, 32'h0000_0000, `RESP_OKAY);
		cyc(3);
		check("irq", 32'h0000_0000, {31'h0, irq});
		done("reset");
		for (int i = 0; i < 3; i++) begin
			b = 8'($urandom);
			wr(`OFS_TXBUF, {24'h0, b}, `RESP_OKAY);
			rchk("tx_flag", `OFS_IRQ_FLAG, 32'h0000_0008, 32'h0000_0000);
			check("tx_char", {24'h0, b}, {24'h0, tx_char});
			check("tx_valid", 32'h0000_0001, {31'h0, tx_char_valid});
			tx_char_taken <= 1'h1;
			cyc(1);
			tx_char_taken <= 1'h0;
			rchk("tx_flag", `OFS_IRQ_FLAG, 32'h0000_0008, 32'h0000_0008);
		end
		done("transmit");
		wr(`OFS_IRQ_EN, 32'h0000_0004, `RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			b = 8'($urandom);
			rx_in <= '{strobe: 1'h1, data: b};
			cyc(1);
			rx_in <= '{strobe: 1'h0, data: b};
			cyc(3);
			check("irq", 32'h0000_0001, {31'h0, irq});
			rchk("rx_flag", `OFS_IRQ_FLAG, 32'h0000_0004, 32'h0000_0004);
			rchk("rx_char", `OFS_RXBUF, 32'h0000_00FF, {24'h0, b});
			rchk("rx_flag", `OFS_IRQ_FLAG, 32'h0000_0004, 32'h0000_0000);
			check("irq", 32'h0000_0000, {31'h0, irq});
		end
		wr(`OFS_IRQ_EN, 32'h0000_0000, `RESP_OKAY);
		done("receive");
		wr(`OFS_EVT_EN, 32'h0000_00FF, `RESP_OKAY);
		rchk("evt_en", `OFS_EVT_EN, 32'h0000_00FF, 32'h0000_000F);
		nack_rcvd <= 1'h1;
		cyc(1);
		nack_rcvd <= 1'h0;
		cyc(3);
		check("irq", 32'h0000_0001, {31'h0, irq});
		arb_lost <= 1'h1;
		cyc(1);
		arb_lost <= 1'h0;
		rchk("status", `OFS_STATUS, 32'h0000_0009, 32'h0000_0008);
		master_mode <= 1'h1;
		arb_lost <= 1'h1;
		cyc(1);
		arb_lost <= 1'h0;
		rchk("arb", `OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
		wr(`OFS_STATUS, 32'h0000_007E, `RESP_OKAY);
		rchk("arb", `OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
		done("events");
		P.start(8);
		rchk("status", `OFS_STATUS, 32'h0000_00FF,
		     32'h0000_0052);
		wr(`OFS_OWN, 32'h0000_8385, `RESP_OKAY);
		addr(10'h000, 1'h1, 1'h1);
		addr(10'h005, 1'h1, 1'h0);
		rchk("gc", `OFS_STATUS, 32'h0000_0020, 32'h0000_0020);
		P.stop(8);
		rchk("status", `OFS_STATUS, 32'h0000_00FF,
		     32'h0000_0024);
		P.start(12);
		rchk("status", `OFS_STATUS, 32'h0000_0024, 32'h0000_0000);
		wr(`OFS_OWN, 32'h0000_0385, `RESP_OKAY);
		addr(10'h000, 1'h0, 1'h0);
		rchk("gc", `OFS_STATUS, 32'h0000_0020, 32'h0000_0000);
		wr(`OFS_MODE, 32'h0000_0001, `RESP_OKAY);
		addr(10'h005, 1'h0, 1'h0);
		addr(10'h385, 1'h1, 1'h0);
		P.stop(4);
		wr(`OFS_EVT_EN, 32'h0000_0000, `RESP_OKAY);
		done("bus");
		wr(`OFS_TARGET, 32'h0000_02A5, `RESP_OKAY);
		wr(`OFS_MODE, 32'h0000_0000, `RESP_OKAY);
		cyc(2);
		d = exp_addr(10'h2A5, 1'h0);
		check("target", d, {22'h0, target_addr_out});
		wr(`OFS_MODE, 32'h0000_0002, `RESP_OKAY);
		cyc(2);
		d = exp_addr(10'h2A5, 1'h1);
		check("target", d, {22'h0, target_addr_out});
		master_mode <= 1'h0;
		cyc(3);
		check("target", 32'h0000_0000, {22'h0, target_addr_out});
		done("target");
		close_out();
	end
endmodule
